/* pbd_decoder.sv */
// Host-side protection bit map decoder with an APB register port
//
// Behaviour
// - start field zero means protection bit zero
// - nonzero field is signed adder on 2^m+1
// - positions step by one, span equals blocks, twice blocks for 8K
// - sector types 2, 3, 4 mean 8K, 32K, 64K
// - 8K and 32K counts are two to n
// - 64K count is two to m minus two
// - density m is 4 to 8
// - bottom 8K adders are minus one, four
// - 8K odd positions read lock, even write
// - bottom 32K single bit at minus three
// - 64K run starts at bit zero, ends minus four
// - top 32K single bit at minus two
// - top 8K adders are seven and fourteen
// - section is type, count, start, end bytes
`timescale 1ns/10ps
module pbd_decoder
   import pbd_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Walk activity
   output logic                      busy
);
   import pbd_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Field to bit position
   function automatic logic [POS_W-1:0] bit_pos(input logic [7:0] f,
                                               input logic [M_W-1:0] m);
      int v;
      v = (1 << m) + 1 + int'($signed(f));
      if (f == 8'h00)
         return '0;
      return POS_W'(v);
   endfunction

   // Log2 of block size, zero for an unknown type
   function automatic int block_shift(input logic [7:0] t);
      case (t)
         TYPE_8K:  return SHIFT_8K;
         TYPE_32K: return SHIFT_32K;
         TYPE_64K: return SHIFT_64K;
         default:  return 0;
      endcase
   endfunction

   // Blocks in a section
   function automatic logic [SUM_W-1:0] block_count(input pbd_section_t s,
                                                   input logic [M_W-1:0] m);
      if (s.sec_type == TYPE_64K)
         return (SUM_W'(1) << m) - SUM_W'(2);
      if (s.count_n >= 8'(N_SAT))
         return SUM_W'(1) << N_SAT;
      return SUM_W'(1) << s.count_n;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PBD_IDLE, PBD_WALK, PBD_DONE} pbd_state_t;

   pbd_state_t          state;                  // Walk state
   logic [M_W-1:0]      dens_m;                 // Density constant
   pbd_section_t        sec_tab [NUM_SEC];      // Section words
   logic [ADDR_W-1:0]   q_addr;                 // Query address
   logic [SEC_IDX_W-1:0] sec_idx;               // Section under test
   logic [SUM_W-1:0]    base;                   // Section base address
   pbd_result_t         result;                 // Last answer
   logic [ST_W-1:0]     status;                 // Status flags

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic bus_acc;                               // Access phase, answer due
   logic bus_wr;                                // Write takes effect
   logic sec_hit;                               // Address falls on a section
   logic [SEC_IDX_W-1:0] sec_sel;               // Which section word
   logic q_wr;                                  // Accepted query write
   logic m_ok;                                  // Legal density write
   logic bad;                                   // Access answered with error

   assign bus_acc = psel & penable & ~pready;
   assign bus_wr  = psel & penable & pready & pwrite & ~pslverr;
   assign sec_sel = SEC_IDX_W'((paddr - OFF_SEC0) >> 2);
   assign sec_hit = (paddr >= OFF_SEC0) && (paddr < OFF_QUERY) && (paddr[1:0] == 2'b00)
                    && (sec_sel < SEC_IDX_W'(NUM_SEC));
   assign q_wr    = bus_wr & (paddr == OFF_QUERY);
   assign m_ok    = (pwdata[M_W-1:0] >= M_MIN) && (pwdata[M_W-1:0] <= M_MAX)
                    && (pwdata[31:M_W] == '0);

   // Errors: unmapped, illegal m, writes to read-only, edits while busy
   always_comb
   begin
      bad = 1'b1;
      if (paddr == OFF_CTRL)
         bad = pwrite & (~m_ok | busy);
      else if (sec_hit)
         bad = pwrite & busy;
      else if (paddr == OFF_QUERY)
         bad = pwrite & busy;
      else if (paddr == OFF_RESULT || paddr == OFF_STATUS)
         bad = pwrite;
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------

   // One wait state, then pready with data and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else if (ce)
      begin
         pready  <= bus_acc;
         pslverr <= bus_acc & bad;
         prdata  <= '0;
         if (bus_acc && !pwrite && !bad)
         begin
            if (paddr == OFF_CTRL)
               prdata <= 32'(dens_m);
            else if (sec_hit)
               prdata <= sec_tab[sec_sel];
            else if (paddr == OFF_QUERY)
               prdata <= 32'(q_addr);
            else if (paddr == OFF_RESULT)
               prdata <= (32'(result.rd_bit) << RES_RD_LSB) | 32'(result.wr_bit);
            else
               prdata <= 32'(status);
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------

   // Density constant and section words, held while a walk runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dens_m  <= M_DEF;
         sec_tab <= SEC_DEF;
      end
      else if (ce && bus_wr)
      begin
         if (paddr == OFF_CTRL)
            dens_m <= pwdata[M_W-1:0];
         else if (sec_hit)
            sec_tab[sec_sel] <= pwdata;
      end
   end

   // ----------------------------------------------------------------
   // Section walk
   // ----------------------------------------------------------------
   pbd_section_t     cur;                       // Section under test
   int               shift;                     // Its block size, log2
   logic [SUM_W-1:0] cnt;                       // Its block count
   logic [SUM_W-1:0] limit;                     // First address above it
   logic [SUM_W-1:0] blk;                       // Block index within it
   logic [POS_W-1:0] start_pos;                 // First bit position
   logic [POS_W-1:0] end_pos;                   // Last bit position
   logic             is_8k;                     // Paired lock bits
   logic [SUM_W-1:0] span;                      // Positions the section uses
   logic             found;                     // Query lands here

   assign cur       = sec_tab[sec_idx];
   assign shift     = block_shift(cur.sec_type);
   assign cnt       = block_count(cur, dens_m);
   assign limit     = base + (cnt << shift);
   assign blk       = (SUM_W'(q_addr) - base) >> shift;
   assign start_pos = bit_pos(cur.start_bit, dens_m);
   assign end_pos   = bit_pos(cur.end_bit, dens_m);
   assign is_8k     = (cur.sec_type == TYPE_8K);
   assign span      = is_8k ? (cnt << 1) : cnt;
   assign found     = (shift != 0) && (SUM_W'(q_addr) < limit);

   // Query write starts; one section per cycle, bottom upward
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= PBD_IDLE;
         q_addr  <= '0;
         sec_idx <= '0;
         base    <= '0;
         busy    <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            PBD_IDLE, PBD_DONE:
               if (q_wr)
               begin
                  q_addr  <= pwdata[ADDR_W-1:0];
                  sec_idx <= '0;
                  base    <= '0;
                  busy    <= 1'b1;
                  state   <= PBD_WALK;
               end
            PBD_WALK:
               // Stop on hit, bad type or past the top section
               if (found || shift == 0 || sec_idx == SEC_IDX_W'(NUM_SEC - 1))
               begin
                  busy  <= 1'b0;
                  state <= PBD_DONE;
               end
               else
               begin
                  base    <= limit;
                  sec_idx <= sec_idx + 1'b1;
               end
            default:
               state <= PBD_IDLE;
         endcase
      end
   end

   // Answer kept until the next hit, flags cleared by each new query
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result <= '0;
         status <= '0;
      end
      else if (ce)
      begin
         if (state != PBD_WALK && q_wr)
         begin
            status          <= '0;
            status[ST_BUSY] <= 1'b1;
         end
         else if (state == PBD_WALK)
         begin
            // Declared span must match the block count
            if (shift != 0 && SUM_W'(end_pos) + 1 != SUM_W'(start_pos) + span)
               status[ST_SPAN] <= 1'b1;
            if (shift == 0)
            begin
               status[ST_TYPE] <= 1'b1;
               status[ST_BUSY] <= 1'b0;
               status[ST_DONE] <= 1'b1;
            end
            else if (found)
            begin
               status[ST_HIT]  <= 1'b1;
               status[ST_RDV]  <= is_8k;
               status[ST_BUSY] <= 1'b0;
               status[ST_DONE] <= 1'b1;
               // Even write lock, odd read lock above it
               if (is_8k)
               begin
                  result.wr_bit <= start_pos + POS_W'(blk << 1);
                  result.rd_bit <= start_pos + POS_W'(blk << 1) + 1'b1;
               end
               else
               begin
                  result.wr_bit <= start_pos + POS_W'(blk);
                  result.rd_bit <= '0;
               end
            end
            else if (sec_idx == SEC_IDX_W'(NUM_SEC - 1))
            begin
               status[ST_RNG]  <= 1'b1;
               status[ST_BUSY] <= 1'b0;
               status[ST_DONE] <= 1'b1;
            end
         end
      end
   end

   // Enabled cycles spent in the walk; ce can stall a walk for any time,
   // so its length is only bounded when counted in enabled cycles
   logic [SEC_IDX_W-1:0] walk_len;              // Enabled walk cycles so far

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         walk_len <= '0;
      else if (ce)
         walk_len <= (state == PBD_WALK) ? walk_len + 1'b1 : '0;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   zero_start_a: assert property (cur.start_bit == 8'h00 |-> start_pos == '0)
      else $error("zero start field not decoded as bit zero");

   signed_adder_a: assert property (cur.start_bit == 8'hfd && dens_m == M_DEF
                                    |-> start_pos == POS_W'(30))
      else $error("negative adder decoded wrongly");

   walk_order_a: assert property (state == PBD_WALK && !found && shift != 0
                                  && sec_idx != 3'(NUM_SEC - 1) && ce
                                  |=> base == $past(limit))
      else $error("next section base not above previous");

   bad_type_a: assert property (state == PBD_WALK && shift == 0 && ce
                                |=> status[ST_TYPE] && state == PBD_DONE)
      else $error("unknown sector type not flagged");

   pow_count_a: assert property (cur.sec_type == TYPE_32K && cur.count_n == 8'h00
                                 |-> cnt == SUM_W'(1))
      else $error("32K count not two to n");

   big_count_a: assert property (cur.sec_type == TYPE_64K && dens_m == M_DEF
                                 |-> cnt == SUM_W'(30))
      else $error("64K count not two to m minus two");

   dens_range_a: assert property (dens_m >= M_MIN && dens_m <= M_MAX)
      else $error("density constant out of range");

   lock_pair_a: assert property (status[ST_RDV] && status[ST_DONE]
                                 |-> result.rd_bit == result.wr_bit + 1'b1)
      else $error("read lock not adjacent to write lock");

   single_bit_a: assert property (state == PBD_WALK && found && !is_8k && ce
                                  && cur.start_bit == 8'hfe
                                  |=> result.wr_bit == $past(start_pos))
      else $error("single block bit not at start position");

   query_done_a: assert property (busy |-> walk_len < SEC_IDX_W'(NUM_SEC))
      else $error("query walk did not finish in time");

   walk_end_a: assert property ($fell(busy) |-> status[ST_DONE] && !status[ST_BUSY])
      else $error("walk ended without done flag");

   hit_8k_c: cover property (state == PBD_WALK && found && is_8k);
   hit_64k_c: cover property (state == PBD_WALK && found && cur.sec_type == TYPE_64K);
   out_range_c: cover property (status[ST_RNG] && status[ST_DONE]);
   span_flag_c: cover property (status[ST_SPAN] && status[ST_DONE]);

endmodule

/* pbd_flash_table.sv */
// Behavioural model of the flash side: the parameter table's section map
`timescale 1ns/10ps
module pbd_flash_table
(
   // Density constant of the emulated part
   input  wire logic [pbd_pkg::M_W-1:0] density_m,
   // Section map bottom first, and size of the part in bytes
   output pbd_pkg::pbd_section_t        sec_map [pbd_pkg::NUM_SEC],
   output logic      [24:0]             part_bytes
);
   import pbd_pkg::*;

   // ----------------------------------------------------------------
   // Table content
   // ----------------------------------------------------------------
   // Adders are relative to 2^m+1, so one table serves every density
   always_comb
   begin
      // Bottom four 8K blocks, odd bits read lock
      sec_map[0] = '{8'h04, 8'hff, 8'h02, TYPE_8K};
      // Bottom 32K block, one bit
      sec_map[1] = '{8'hfd, 8'hfd, 8'h00, TYPE_32K};
      // 64K run from bit zero; the host derives its count from m
      sec_map[2] = '{8'hfc, 8'h00, 8'h00, TYPE_64K};
      // Top 32K block, one bit
      sec_map[3] = '{8'hfe, 8'hfe, 8'h00, TYPE_32K};
      // Top four 8K blocks, positive adders
      sec_map[4] = '{8'h0e, 8'h07, 8'h02, TYPE_8K};
      // Only densities 4 to 8 are meaningful
      part_bytes = 25'h1 << (32'(density_m) + 16);
   end
endmodule

/* pbd_pkg.sv */
// Package for the protection bit map decoder: map offsets, field layout, defaults
package pbd_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 24;           // Flash byte address width
   localparam int POS_W    = 10;           // Protection bit position width
   localparam int SUM_W    = 40;           // Wide walk arithmetic
   localparam int NUM_SEC  = 5;            // Sections in the map
   localparam int SEC_IDX_W = 3;           // Section counter width
   localparam int M_W      = 4;            // Density constant width
   localparam int N_SAT    = 24;           // Exponents at or above saturate

   // ----------------------------------------------------------------
   // APB register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;  // Density constant m
   localparam logic [7:0] OFF_SEC0   = 8'h10;  // Section words, one per word
   localparam logic [7:0] OFF_QUERY  = 8'h30;  // Query byte address
   localparam logic [7:0] OFF_RESULT = 8'h34;  // Write and read lock bit indices
   localparam logic [7:0] OFF_STATUS = 8'h38;  // Walk status
   localparam int         RES_RD_LSB = 16;     // Read lock index position

   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_HIT  = 2;
   localparam int ST_RDV  = 3;
   localparam int ST_RNG  = 4;
   localparam int ST_TYPE = 5;
   localparam int ST_SPAN = 6;
   localparam int ST_W    = 7;

   // ----------------------------------------------------------------
   // Sector types and block sizes
   // ----------------------------------------------------------------
   localparam logic [7:0] TYPE_8K  = 8'h02;
   localparam logic [7:0] TYPE_32K = 8'h03;
   localparam logic [7:0] TYPE_64K = 8'h04;
   localparam int SHIFT_8K  = 13;
   localparam int SHIFT_32K = 15;
   localparam int SHIFT_64K = 16;

   // Density constant range and default
   localparam logic [M_W-1:0] M_MIN = 4'h4;
   localparam logic [M_W-1:0] M_MAX = 4'h8;
   localparam logic [M_W-1:0] M_DEF = 4'h5;

   // One section: four byte fields, type in the low byte
   typedef struct packed {
      logic [7:0] end_bit;                 // protection_end_bit_field
      logic [7:0] start_bit;               // protection_start_bit_field
      logic [7:0] count_n;                 // Number of sectors exponent
      logic [7:0] sec_type;                // Sector type
   } pbd_section_t;

   // Decoded answer of one query
   typedef struct packed {
      logic [POS_W-1:0] wr_bit;            // Write lock bit index
      logic [POS_W-1:0] rd_bit;            // Read lock bit index
   } pbd_result_t;

   // Default map, bottom to top
   localparam pbd_section_t SEC_DEF [NUM_SEC] = '{
      '{end_bit: 8'h04, start_bit: 8'hff, count_n: 8'h02, sec_type: TYPE_8K},
      '{end_bit: 8'hfd, start_bit: 8'hfd, count_n: 8'h00, sec_type: TYPE_32K},
      '{end_bit: 8'hfc, start_bit: 8'h00, count_n: 8'h00, sec_type: TYPE_64K},
      '{end_bit: 8'hfe, start_bit: 8'hfe, count_n: 8'h00, sec_type: TYPE_32K},
      '{end_bit: 8'h0e, start_bit: 8'h07, count_n: 8'h02, sec_type: TYPE_8K}
   };

endpackage

/* tb.sv */
// Self-checking bench for the protection bit map decoder
`timescale 1ns/10ps
module tb;
   import pbd_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic         pclk, presetn, ce, psel, penable, pwrite;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [31:0]  exp_res;              // Answer the decoder should hold now
   logic         pready, pslverr, busy, err;
   logic [3:0]   m_cur;                // Density shared by model and bench
   logic [24:0]  part_bytes;           // Part size from the model
   pbd_section_t tbl [NUM_SEC];        // Table held by the flash model
   logic [31:0]  sec [NUM_SEC];        // Mirror of the section registers
   int           n_mismatch, cmp_count, cycles;
   realtime      t_rel;                // Time of the last bus release

   pbd_decoder uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
   pbd_flash_table flash (.density_m(m_cur), .sec_map(tbl), .part_bytes(part_bytes));

   always #10 pclk = ~pclk;

   // Hang guard: a stuck handshake ends the run as a failure
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Tasks and expectation functions
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // One APB transfer; an idle cycle only when the bus was just released
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      if (t_rel == $realtime)
         @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      t_rel = $realtime;
   endtask

   function automatic int pos(input logic [7:0] f);
      return (f == 8'h00) ? 0 : (1 << m_cur) + 1 + int'($signed(f));
   endfunction

   function automatic int shift(input int i);
      return (sec[i][7:0] == TYPE_8K) ? SHIFT_8K :
             (sec[i][7:0] == TYPE_32K) ? SHIFT_32K : SHIFT_64K;
   endfunction

   function automatic longint blocks(input int i);
      return (sec[i][7:0] == TYPE_64K) ? (64'd1 << m_cur) - 2 :
             64'd1 << sec[i][15:8];
   endfunction

   // Expected RESULT, STATUS and walk length of one query
   function automatic void predict(input logic [23:0] a, output logic [31:0] res,
                                   output logic [31:0] st, output int k);
      longint base, idx;
      int     s, w;
      logic   e8;
      base = 0;
      res = exp_res;                   // A miss leaves the last answer in place
      st = 32'h2;
      for (int i = 0; i < NUM_SEC; i++)
      begin
         k = i + 1;
         e8 = (sec[i][7:0] == TYPE_8K);
         if (sec[i][7:0] < TYPE_8K || sec[i][7:0] > TYPE_64K)
         begin
            st[ST_TYPE] = 1'b1;
            k = -1;
            return;
         end
         s = pos(sec[i][23:16]);
         w = int'(e8 ? 2 * blocks(i) : blocks(i));
         if (pos(sec[i][31:24]) + 1 != s + w)
            st[ST_SPAN] = 1'b1;
         if (a < base + (blocks(i) << shift(i)))
         begin
            idx = (a - base) >> shift(i);
            res[9:0] = 10'(e8 ? s + 2 * idx : s + idx);
            res[25:16] = e8 ? 10'(s + 2 * idx + 1) : 10'h0;
            st[ST_RDV] = e8;
            st[ST_HIT] = 1'b1;
            exp_res = res;
            return;
         end
         base += blocks(i) << shift(i);
      end
      st[ST_RNG] = 1'b1;
   endfunction

   // One query: busy length in enabled cycles, then STATUS and RESULT
   task automatic query(input logic [23:0] a);
      logic [31:0] res, st;
      int          k, n;
      predict(a, res, st, k);
      apb(1'b1, OFF_QUERY, {8'h00, a});
      n = 0;
      repeat (60)
      begin
         @(posedge pclk);
         if (ce === 1'b1 && busy === 1'b1)
            n++;
         else if (n > 0 && busy === 1'b0)
            break;
         ce <= ($urandom % 4) != 0;
      end
      ce <= 1'b1;
      if (k > 0)
         check("walk cycles", n, k);
      apb(1'b0, OFF_STATUS, 0);
      check("status", rd, st);
      apb(1'b0, OFF_RESULT, 0);
      check("result", rd, res);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [40:0] bad [7];                        // Refused accesses: wr, addr, data
      longint      base;
      logic [31:0] res_x, st_x;                    // Expected answer of a bare query
      int          k_x;
      bad = '{{1'b1, OFF_CTRL, 32'h3}, {1'b1, OFF_CTRL, 32'h9}, {1'b1, OFF_CTRL, 32'h15},
              {1'b1, OFF_RESULT, 32'h1}, {1'b1, OFF_STATUS, 32'h1},
              {1'b0, 8'h3c, 32'h0}, {1'b0, 8'h12, 32'h0}};
      pclk = 0;
      presetn = 0;
      ce = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      m_cur = 4'h5;
      t_rel = -1;
      exp_res = 0;
      void'($urandom(79747));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset contents against the device table
      foreach (sec[i])
         sec[i] = tbl[i];
      apb(1'b0, OFF_CTRL, 0);
      check("ctrl reset", rd, 32'h5);
      for (int i = 0; i < NUM_SEC; i++)
      begin
         apb(1'b0, OFF_SEC0 + 8'(4 * i), 0);
         check("section reset", rd, sec[i]);
      end
      foreach (bad[i])
      begin
         apb(bad[i][40], bad[i][39:32], bad[i][31:0]);
         check("refused", {rd[30:0], err}, 32'h1);
      end
      apb(1'b0, OFF_CTRL, 0);
      check("ctrl kept", rd, 32'h5);
      // Every density: section edges, map top, random lookups
      for (int m = 4; m <= 8; m++)
      begin
         m_cur = 4'(m);
         apb(1'b1, OFF_CTRL, 32'(m));
         check("ctrl accept", err, 1'b0);
         base = 0;
         for (int i = 0; i < NUM_SEC; i++)
         begin
            if (base > 0)
               query(24'(base - 1));
            query(24'(base));
            base += blocks(i) << shift(i);
         end
         check("map size", 32'(base), {7'h0, part_bytes});
         query(24'(base - 1));
         if (base < 64'h1000000)
            query(24'(base));
         repeat (4) query(24'($urandom % base));
      end
      // Orders during a walk are refused; a five section walk has room for one
      apb(1'b1, OFF_QUERY, 32'hffffff);
      apb(1'b1, OFF_QUERY, 32'h0);
      check("query busy", err, 1'b1);
      repeat (8) @(posedge pclk);
      predict(24'hffffff, res_x, st_x, k_x);
      apb(1'b1, OFF_QUERY, 32'hffffff);
      apb(1'b1, OFF_CTRL, 32'h4);
      check("ctrl busy", err, 1'b1);
      repeat (8) @(posedge pclk);
      apb(1'b0, OFF_CTRL, 0);
      check("ctrl kept busy", rd, 32'h8);
      apb(1'b0, OFF_RESULT, 0);
      check("first query kept", rd, res_x);
      // Random section sizes and adders at density 5
      m_cur = 4'h5;
      apb(1'b1, OFF_CTRL, 32'h5);
      repeat (3)
      begin
         sec[0][15:8] = 8'($urandom % 4);
         sec[1][15:8] = 8'($urandom % 3);
         sec[4][31:24] = 8'($urandom);
         for (int i = 0; i < NUM_SEC; i++)
            apb(1'b1, OFF_SEC0 + 8'(4 * i), sec[i]);
         check("section write", err, 1'b0);
         repeat (5) query(24'($urandom % 32'h200000));
      end
      // Unknown sector type stops the walk
      sec[2][7:0] = 8'h01;
      apb(1'b1, OFF_SEC0 + 8'h08, sec[2]);
      query(24'h1fffff);
      report_and_stop();
   end
endmodule
